// [verilog/adcc_cfg.svh]
/*
  Constants of the converter control block: register offsets, field
  positions, reset values and timing figures.
  Assumes a 250 MHz pclk and a 32-bit APB register bus.
*/
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

`define ADCC_CTRL_OFF 8'h00
`define ADCC_STAT_OFF 8'h04

`define ADCC_F_SRC_LSB 0
`define ADCC_F_SRC_MSB 5
`define ADCC_F_FAST 6
`define ADCC_F_CLK_LSB 7
`define ADCC_F_CLK_MSB 8
`define ADCC_F_SPD_LSB 9
`define ADCC_F_SPD_MSB 10
`define ADCC_F_REF_LSB 11
`define ADCC_F_REF_MSB 12
`define ADCC_F_WS 13

`define ADCC_SPEED_100K 2'h2
`define ADCC_REF_RSVD 2'h1
`define ADCC_REF_INT 2'h0

`define ADCC_CLK_MHZ 250
`define ADCC_SLOW_PU_US 500
`define ADCC_FAST_PU_US 5

`define ADCC_CONV_LEN 5'h10
`define ADCC_SER_FIRST 5'h06
`define ADCC_SER_LAST 5'h0d
`define ADCC_PAR_AT 5'h0a

`endif

// [verilog/adcc_pkg.sv]
/*
  Types shared by the converter control block.
  Assumes adcc_cfg.svh for all numeric constants.
*/
package adcc_pkg;
  // Software visible configuration
  typedef struct packed {
    logic wake_sleep;
    logic [1:0] ref_sel;
    logic [1:0] speed;
    logic [1:0] clk_sel;
    logic fast_on;
    logic [5:0] pd_src;
  } adcc_cfg_t;

  // Controls toward the analog macrocell
  typedef struct packed {
    logic conv_powerdown;
    logic macro_powerdown;
    logic [1:0] speed;
    logic [1:0] ref_sel;
    logic wake_sleep;
    logic dac_blocked;
  } adcc_analog_ctl_t;

  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b01,
    ADCC_CONV = 2'b10
  } adcc_state_t;
endpackage

// [verilog/adcc_top.sv]
/*
  Converter control: APB registers, power-down sequencing, conversion clock
  choice, sixteen-cycle conversion, serial result pin and a parallel result
  FIFO.
  Assumes clock sources, matrix outputs and converter code are asynchronous.
*/
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "adcc_cfg.svh"

module adcc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } adcc_fifo_st_t;
  adcc_fifo_st_t q, next_q;
  logic push, pop;

  // Full and empty come straight from the count
  assign in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign level = q.cnt;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers wrap at DEPTH, so depths other than powers of two work too
  always_comb begin
    next_q = q;
    if (push) begin
      next_q.mem[q.wp] = in_data;
      next_q.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
    end
    if (pop) begin
      next_q.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + AW'(1);
    end
    next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

module adcc_top #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int SLOW_PU_CYCLES = `ADCC_SLOW_PU_US * `ADCC_CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [63:0] powerdown_route_output,
  input wire logic ring_osc_clk,
  input wire logic fabric_clock_route_output,
  input wire logic rc_osc_clk,
  input wire logic serial_if_clk,
  input wire logic [WIDTH-1:0] converter_code,
  output adcc_pkg::adcc_analog_ctl_t analog_ctl,
  output logic converter_ready,
  output logic serial_result,
  output logic serial_result_oe,
  output logic parallel_result_valid,
  input wire logic parallel_result_ready,
  output logic [WIDTH-1:0] parallel_result
);
  import adcc_pkg::*;

  localparam int FAST_PU_CYCLES = `ADCC_FAST_PU_US * `ADCC_CLK_MHZ;
  localparam int LW = $clog2(DEPTH) + 1;

  typedef struct packed {
    adcc_cfg_t cfg;
    logic [63:0] route_s1;
    logic [63:0] route_s2;
    logic [3:0] clk_s1;
    logic [3:0] clk_s2;
    logic [WIDTH-1:0] code_s1;
    logic [WIDTH-1:0] code_s2;
    logic clk_prev;
    logic req_prev;
    adcc_state_t st;
    logic [4:0] cnt;
    logic [WIDTH-1:0] sample;
    logic pushed;
    logic ser_bit;
    logic ser_oe;
    logic warm;
    logic [16:0] pu_cnt;
    logic [31:0] rdata;
    logic slverr;
  } adcc_st_t;
  adcc_st_t q, next_q;

  logic req, tick, sel_clk, fifo_in_ready, push, acc, hit_ctrl, hit_stat;
  logic [LW-1:0] level;

  // The request is one synchronised matrix output picked by the source field
  assign req = q.route_s2[q.cfg.pd_src];
  // Clock choice 00 ring, 01 matrix, 10 RC, 11 serial interface clock
  assign sel_clk = q.clk_s2[q.cfg.clk_sel];
  assign tick = sel_clk & ~q.clk_prev;
  assign push = (q.st == ADCC_CONV) && (q.cnt == `ADCC_PAR_AT) && !q.pushed;
  assign acc = psel & penable;
  assign hit_ctrl = (paddr[7:0] == `ADCC_CTRL_OFF) && (paddr[31:8] == '0);
  assign hit_stat = (paddr[7:0] == `ADCC_STAT_OFF) && (paddr[31:8] == '0);

  // Zero wait state slave; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = q.slverr;

  // Converter powers down on the request; macrocell only in slow mode
  assign analog_ctl.conv_powerdown = req;
  assign analog_ctl.macro_powerdown = req & ~q.cfg.fast_on;
  assign analog_ctl.speed = q.cfg.speed;
  assign analog_ctl.ref_sel = q.cfg.ref_sel;
  assign analog_ctl.wake_sleep = q.cfg.wake_sleep;
  assign analog_ctl.dac_blocked = ~req | (q.st == ADCC_CONV);
  // Not ready in the cycle the request falls, before the count is loaded
  assign converter_ready = ~req & ~q.req_prev & (q.pu_cnt == '0);
  assign serial_result = q.ser_bit;
  assign serial_result_oe = q.ser_oe;

  always_comb begin
    next_q = q;
    // Two flops on every asynchronous input before it is looked at
    next_q.route_s1 = powerdown_route_output;
    next_q.route_s2 = q.route_s1;
    next_q.clk_s1 = {serial_if_clk, rc_osc_clk, fabric_clock_route_output, ring_osc_clk};
    next_q.clk_s2 = q.clk_s1;
    next_q.code_s1 = converter_code;
    next_q.code_s2 = q.code_s1;
    next_q.clk_prev = sel_clk;
    next_q.req_prev = req;

    // Register writes; reserved speed and reference codes are refused
    if (acc && pwrite && hit_ctrl) begin
      next_q.cfg.pd_src = pwdata[`ADCC_F_SRC_MSB:`ADCC_F_SRC_LSB];
      next_q.cfg.fast_on = pwdata[`ADCC_F_FAST];
      next_q.cfg.clk_sel = pwdata[`ADCC_F_CLK_MSB:`ADCC_F_CLK_LSB];
      next_q.cfg.wake_sleep = pwdata[`ADCC_F_WS];
      if (pwdata[`ADCC_F_SPD_MSB:`ADCC_F_SPD_LSB] == `ADCC_SPEED_100K) begin
        next_q.cfg.speed = `ADCC_SPEED_100K;
      end
      if (pwdata[`ADCC_F_REF_MSB:`ADCC_F_REF_LSB] != `ADCC_REF_RSVD) begin
        next_q.cfg.ref_sel = pwdata[`ADCC_F_REF_MSB:`ADCC_F_REF_LSB];
      end
    end
    // Read data and error are set up one cycle ahead of the access phase
    next_q.rdata = '0;
    next_q.slverr = 1'b0;
    if (psel && !penable) begin
      next_q.slverr = !(hit_ctrl || hit_stat);
      if (!pwrite && hit_ctrl) begin
        next_q.rdata = 32'(q.cfg);
      end else if (!pwrite && hit_stat) begin
        next_q.rdata = {8'h00, 8'(q.sample), 8'(level), 3'h0, q.warm,
                        converter_ready, q.ser_oe, q.st == ADCC_CONV, req};
      end
    end

    // Power-up timing: long while the macrocell warms, short afterwards
    if (analog_ctl.macro_powerdown) begin
      next_q.warm = 1'b0;
    end else if (!req && q.pu_cnt == 17'(1)) begin
      next_q.warm = 1'b1;
    end
    if (req) begin
      next_q.pu_cnt = '0;
    end else if (q.req_prev) begin
      next_q.pu_cnt = q.warm ? 17'(FAST_PU_CYCLES) : 17'(SLOW_PU_CYCLES);
    end else if (q.pu_cnt != '0) begin
      next_q.pu_cnt = q.pu_cnt - 17'(1);
    end

    // Conversion sequencer counts ticks of the chosen conversion clock
    unique case (q.st)
      ADCC_IDLE: begin
        if (req && !q.req_prev) begin
          next_q.st = ADCC_CONV;
          next_q.cnt = '0;
          next_q.pushed = 1'b0;
          next_q.sample = q.code_s2;
        end
      end
      ADCC_CONV: begin
        if (push && fifo_in_ready) begin
          next_q.pushed = 1'b1;
        end
        // A full FIFO holds the sequence at the parallel point
        if (!req) begin
          next_q.st = ADCC_IDLE; // Request dropped early, result abandoned
        end else if (tick && !(push && !fifo_in_ready)) begin
          next_q.cnt = q.cnt + 5'(1);
          if (q.cnt + 5'(1) == `ADCC_CONV_LEN) begin
            next_q.st = ADCC_IDLE;
          end
        end
      end
    endcase

    // Serial bits MSB first over cycles six to thirteen
    next_q.ser_oe = (next_q.st == ADCC_CONV) && (next_q.cnt >= `ADCC_SER_FIRST) &&
                    (next_q.cnt <= `ADCC_SER_LAST);
    next_q.ser_bit = next_q.ser_oe ?
                     next_q.sample[3'(`ADCC_SER_LAST - next_q.cnt)] : 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= ADCC_IDLE;
      q.cfg.speed <= `ADCC_SPEED_100K;
      q.cfg.ref_sel <= `ADCC_REF_INT;
    end else begin
      q <= next_q;
    end
  end

  // Parallel words wait here for the comparator or state machine cells
  adcc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(q.sample),
    .out_valid(parallel_result_valid),
    .out_ready(parallel_result_ready),
    .out_data(parallel_result),
    .level(level)
  );

  a_conv_start: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == ADCC_IDLE && req && !q.req_prev) |=> (q.st == ADCC_CONV && q.cnt == 5'h00))
    else $error("conversion did not start on request");
  a_macro_slow: assert property (@(posedge pclk) disable iff (!presetn)
    (!q.cfg.fast_on && analog_ctl.conv_powerdown) |-> analog_ctl.macro_powerdown)
    else $error("macrocell not powered down in slow mode");
  a_macro_fast: assert property (@(posedge pclk) disable iff (!presetn)
    q.cfg.fast_on |-> !analog_ctl.macro_powerdown)
    else $error("macrocell powered down in fast mode");
  a_pu_slow: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(req) && !q.warm) |=> q.pu_cnt == 17'(SLOW_PU_CYCLES))
    else $error("slow power-up count wrong");
  a_conv_end: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == ADCC_CONV && req && tick && q.cnt == 5'h0f) |=> q.st == ADCC_IDLE)
    else $error("conversion not sixteen cycles");
  a_ser_window: assert property (@(posedge pclk) disable iff (!presetn)
    serial_result_oe |-> (q.cnt >= 5'h06 && q.cnt <= 5'h0d && q.st == ADCC_CONV))
    else $error("serial output outside its window");
  a_ser_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (serial_result_oe && q.cnt == 5'h06) |-> serial_result == q.sample[WIDTH-1])
    else $error("serial MSB wrong");
  a_par_point: assert property (@(posedge pclk) disable iff (!presetn)
    push |-> (q.cnt == 5'h0a && !q.pushed))
    else $error("parallel result pushed at wrong cycle");
  a_speed_legal: assert property (@(posedge pclk) disable iff (!presetn)
    q.cfg.speed == 2'h2)
    else $error("reserved speed code stored");
  a_ref_legal: assert property (@(posedge pclk) disable iff (!presetn)
    q.cfg.ref_sel != 2'h1)
    else $error("reserved reference code stored");
  a_dac_share: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == ADCC_CONV) |-> analog_ctl.dac_blocked)
    else $error("shared converter free during conversion");
endmodule

// [testbench/adcc_far_side.sv]
/*
  Far-side model: matrix route carrying the request, four conversion
  clock sources and the converter code.
  Assumes pclk at 250 MHz; sources run free with a phase offset from pclk.
*/
`timescale 1ns/1ps
module adcc_far_side (
  input wire logic pclk,
  input wire logic req,
  input wire logic [5:0] src,
  input wire logic [7:0] code,
  output logic [63:0] powerdown_route_output,
  output logic [3:0] clks,
  output logic [7:0] converter_code
);
  // Slow sources keep the sample rate low; odd offset avoids pclk edges
  for (genvar i = 0; i < 4; i++) begin : g_osc
    logic ck;
    initial begin
      ck = 1'b0;
      #1;
      forever #(80 + 16 * i) ck = ~ck;
    end
    assign clks[i] = ck;
  end
  // Only the chosen route output carries the request
  initial powerdown_route_output = '0;
  initial converter_code = '0;
  always @(posedge pclk) begin
    powerdown_route_output <= 64'(req) << src;
    converter_code <= code;
  end
endmodule

// [testbench/adc_conversion_control_tb.sv]
/*
  Self-checking bench for the converter control: APB tasks and
  conversion sequences with expected values.
  Assumes adcc_top with a short slow power-up count.
*/
`timescale 1ns/1ps
module adc_conversion_control_tb;
  import adcc_pkg::*;
  localparam int PU = 50;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, err, serial_result, serial_result_oe, parallel_result_valid;
  logic parallel_result_ready = 1'b0, req = 1'b0, fast = 1'b0, converter_ready;
  logic [5:0] src = '0;
  logic [7:0] code = '0, converter_code, parallel_result;
  logic [63:0] route;
  logic [3:0] clks;
  logic [1:0] sel = '0;
  adcc_analog_ctl_t analog_ctl;
  int bad_count = 0, n_tests = 0, cyc = 0, t_push = 0;
  logic [7:0] pushed[$];
  logic [31:0] wv[4] = '{32'h0000_2bff, 32'h0000_1000, 32'h0000_3e00, 32'h0000_0400};
  logic [31:0] ev[4] = '{32'h0000_25ff, 32'h0000_1400, 32'h0000_3c00, 32'h0000_0400};
  int pu_tab[4] = '{PU, 1250, PU, 1250};

  adcc_top #(.SLOW_PU_CYCLES(PU)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .powerdown_route_output(route),
    .ring_osc_clk(clks[0]), .fabric_clock_route_output(clks[1]), .rc_osc_clk(clks[2]),
    .serial_if_clk(clks[3]), .converter_code(converter_code), .analog_ctl(analog_ctl),
    .converter_ready(converter_ready), .serial_result(serial_result),
    .serial_result_oe(serial_result_oe), .parallel_result_valid(parallel_result_valid),
    .parallel_result_ready(parallel_result_ready), .parallel_result(parallel_result));
  adcc_far_side far (.pclk(pclk), .req(req), .src(src), .code(code),
    .powerdown_route_output(route), .clks(clks), .converter_code(converter_code));

  initial forever #2 pclk = ~pclk;
  // Cycle count, popped words and the watchdog
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (parallel_result_valid === 1'b1 && parallel_result_ready) begin
      pushed.push_back(parallel_result);
      t_push <= cyc;
    end
    if (cyc == 60000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic check_range(input int got, input int lo, input int hi, input string what);
    n_tests++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s %0d not in %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is read while it stands in the access cycle, then the edge ends it
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Control written only while idle, never mid conversion
  task automatic setup(input int s, input logic f);
    sel = 2'(s);
    fast = f;
    src <= 6'(10 + s);
    apb(1'b1, '0, 32'(10 + s) | (32'(f) << 6) | (32'(s) << 7) | 32'h0000_0400);
  endtask
  task automatic convert(input logic [7:0] c, input int pu_exp);
    int t0, t1, per;
    logic [7:0] bits;
    per = 40 + 8 * sel;
    @(posedge pclk);
    code <= c;
    req <= 1'b1;
    t0 = cyc;
    while (serial_result_oe !== 1'b1) @(posedge pclk);
    t1 = cyc;
    check_range(t1 - t0, 5 * per, 6 * per + 8, "serial start");
    check({31'h0, analog_ctl.dac_blocked}, 32'h1, "dac busy");
    check({30'h0, analog_ctl.conv_powerdown, analog_ctl.macro_powerdown}, {30'h0, 1'b1, !fast}, "pd");
    for (int i = 7; i >= 0; i--) begin
      @(negedge clks[sel]);
      bits[i] = serial_result;
    end
    check({24'h0, bits}, {24'h0, c}, "serial bits");
    while (serial_result_oe === 1'b1) @(posedge pclk);
    check_range(cyc - t1, 8 * per - 4, 8 * per + 4, "serial span");
    if (parallel_result_ready) begin
      check_range(t_push - t0, 9 * per, 10 * per + 8, "parallel start");
      check({24'h0, pushed.pop_front()}, {24'h0, c}, "parallel word");
    end
    repeat (24) @(posedge clks[sel]);
    @(posedge pclk);
    req <= 1'b0;
    t0 = cyc;
    while (converter_ready !== 1'b1) @(posedge pclk);
    check_range(cyc - t0, pu_exp, pu_exp + 6, "power-up");
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, '0, '0);
    check(rd, 32'h0000_0400, "ctrl reset");
    check({24'h0, analog_ctl}, 32'h0000_0021, "analog reset");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, '0, wv[i]);
      apb(1'b0, '0, '0);
      check(rd, ev[i], "ctrl fields");
      check({24'h0, analog_ctl}, {26'h0, ev[i][10:9], ev[i][12:11], ev[i][13], 1'b1}, "ctl");
    end
    apb(1'b0, 32'h0000_0008, '0);
    check({rd[30:0], err}, 32'h0000_0001, "unmapped read");
    apb(1'b1, 32'h0000_0004, 32'hffff_ffff);
    check({31'h0, err}, 32'h0, "status write");
    $display("test registers done");
    parallel_result_ready <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      setup(s, s != 2);
      convert(8'(8'ha5 + 8'h3b * s), pu_tab[s]);
    end
    $display("test conversions done");
    setup(0, 1'b1);
    parallel_result_ready <= 1'b0;
    for (int i = 1; i < 9; i++) convert(8'(8'h11 * i), 1250);
    @(posedge pclk);
    code <= 8'h99;
    req <= 1'b1;
    repeat (20) @(posedge clks[0]);
    apb(1'b0, 32'h0000_0004, '0);
    check(rd & 32'h0000_ff07, 32'h0000_0807, "full stall");
    parallel_result_ready <= 1'b1;
    while (serial_result_oe === 1'b1) @(posedge pclk);
    repeat (20) @(posedge clks[0]);
    @(posedge pclk);
    req <= 1'b0;
    check(32'(pushed.size()), 32'h9, "drain count");
    for (int i = 0; i < 9; i++) check({24'h0, pushed[i]}, 32'(8'(8'h11 * (i + 1))), "order");
    apb(1'b0, 32'h0000_0004, '0);
    check({24'h0, rd[15:8]}, 32'h0, "empty");
    $display("test fifo done");
    end_sim();
  end
endmodule
